/* File: logic/vomep_top.sv */
// Vector operand legality checker and element policy unit with APB access
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module vomep_top
    import vomep_pkg::*;
#(
    parameter int VLEN = 128,
    parameter int IW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic illegal_pulse,
    output logic scalar_we
);
    localparam int VLEN_LOG = $clog2(VLEN);

    typedef struct packed {
        vomep_st_type st;
        logic [7:0] vtype;
        logic [IW-1:0] vl;
        logic [IW-1:0] vstart;
        logic [31:0] inst;
        logic [8:0] opcl;
        logic [31:0] mask;
        logic [IW-1:0] idx;
        logic chk;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic illegal;
        logic scalar_we;
    } vomep_state_type;

    vomep_state_type state_reg;
    vomep_state_type state_next;

    // Signed log2 of the group multiplier; code 4 maps to -4, reserved
    function automatic logic signed [3:0] lmul_log(input logic [2:0] c);
        return $signed({c[2], c});
    endfunction

    // Registers spanned by a group of the given log2 multiplier
    function automatic logic [4:0] nregs(input logic signed [3:0] l);
        logic [4:0] n;
        n = 5'd1;
        if (l > 4'sd0) begin
            n = 5'd1 << l[1:0];
        end
        return n;
    endfunction

    // Base register is a multiple of the group size
    function automatic logic aligned(input logic [4:0] r,
                                     input logic [4:0] n);
        return (r & (n - 5'd1)) == 5'd0;
    endfunction

    // Two register groups share at least one register
    function automatic logic overlap(input logic [4:0] a,
                                     input logic [4:0] na,
                                     input logic [4:0] b,
                                     input logic [4:0] nb);
        return ({1'b0, a} < ({1'b0, b} + {1'b0, nb}))
            && ({1'b0, b} < ({1'b0, a} + {1'b0, na}));
    endfunction

    // Overlap of destination and one source meets the width and position
    // cases; element widths are log2, mask elements count as zero
    function automatic logic ovl_ok(input logic [4:0] d,
                                    input logic [4:0] nd,
                                    input logic signed [4:0] de,
                                    input logic [4:0] s,
                                    input logic [4:0] ns,
                                    input logic signed [4:0] se,
                                    input logic signed [3:0] sl);
        logic ok;
        ok = 1'b1;
        if (overlap(d, nd, s, ns)) begin
            if (de < se) begin
                ok = (d == s);
            end else if (de > se) begin
                ok = (sl >= 4'sd0)
                    && (({1'b0, s} + {1'b0, ns}) == ({1'b0, d} + {1'b0, nd}));
            end
        end
        return ok;
    endfunction

    // Field extraction
    logic [2:0] lmul_code;
    logic [2:0] sew_code;
    logic [4:0] vd;
    logic [4:0] vs1;
    logic [4:0] vs2;
    logic [2:0] f3;
    logic vm;
    logic [1:0] kind;
    logic mdst;
    logic red;
    logic xfw;
    logic us1;
    logic us2;
    logic s1msk;
    logic mask_prod;

    assign lmul_code = state_reg.vtype[VT_LMUL_LSB +: 3];
    assign sew_code = state_reg.vtype[VT_SEW_LSB +: 3];
    assign vd = state_reg.inst[IN_VD_LSB +: 5];
    assign vs1 = state_reg.inst[IN_VS1_LSB +: 5];
    assign vs2 = state_reg.inst[IN_VS2_LSB +: 5];
    assign f3 = state_reg.inst[IN_F3_LSB +: 3];
    assign vm = state_reg.inst[IN_VM]; // RULE14
    assign kind = state_reg.opcl[OC_KIND_LSB +: 2];
    assign mdst = state_reg.opcl[OC_MDST];
    assign red = state_reg.opcl[OC_RED];
    assign xfw = state_reg.opcl[OC_XFW];
    assign s1msk = state_reg.opcl[OC_S1MSK];
    // A vector first source exists only for vector-vector forms
    assign us1 = state_reg.opcl[OC_US1] & (f3 <= 3'd2);
    assign us2 = state_reg.opcl[OC_US2];
    assign mask_prod = mdst & ~state_reg.opcl[OC_MLD]; // RULE18

    // Scalar operand source follows the operand category
    logic [1:0] src_kind;
    always_comb begin
        case (f3)
            3'd3: src_kind = SRC_IMM; // RULE1
            3'd4: src_kind = SRC_XREG;
            3'd6: src_kind = SRC_XREG;
            3'd5: src_kind = SRC_FREG;
            default: src_kind = SRC_VEC0;
        endcase
    end

    // Effective widths and multipliers per operand
    logic signed [3:0] base_l;
    logic signed [4:0] sew_l;
    logic signed [3:0] d_l;
    logic signed [3:0] s1_l;
    logic signed [3:0] s2_l;
    logic signed [4:0] d_e;
    logic signed [4:0] s1_e;
    logic signed [4:0] s2_e;

    always_comb begin
        base_l = lmul_log(lmul_code);
        sew_l = $signed({2'b00, sew_code}) + 5'sd3;
        // Defaults: width SEW and multiplier LMUL
        d_l = base_l; // RULE2
        s1_l = base_l;
        s2_l = base_l;
        d_e = sew_l;
        s1_e = sew_l;
        s2_e = sew_l;
        if (kind == KIND_WIDE) begin
            d_l = base_l + 4'sd1; // RULE3
            d_e = sew_l + 5'sd1;
        end else if (kind == KIND_NARR) begin
            s2_l = base_l + 4'sd1; // RULE3
            s2_e = sew_l + 5'sd1;
        end
        // Reduction scalars sit in one register
        if (red) begin
            d_l = 4'sd0; // RULE9
            s1_l = 4'sd0;
            s1_e = d_e;
        end
        if (mdst) begin
            d_l = 4'sd0;
            d_e = 5'sd0;
        end
        if (s1msk) begin
            s1_l = 4'sd0;
            s1_e = 5'sd0; // RULE5
        end
    end

    logic [4:0] nd;
    logic [4:0] n1;
    logic [4:0] n2;
    assign nd = nregs(d_l);
    assign n1 = nregs(s1_l);
    assign n2 = nregs(s2_l);

    // Vector destination exists unless the result goes to x or f
    logic vdst;
    assign vdst = ~xfw; // RULE1

    // Reserved encoding checks
    logic bad_cfg;
    logic bad_size;
    logic bad_align;
    logic bad_eew;
    logic bad_ovl;
    logic bad_v0;
    logic diff_ovl;
    logic illegal;

    assign bad_cfg = (lmul_code == 3'd4) | (sew_code > 3'd3);
    assign bad_size = (d_l > 4'sd3) | (s1_l > 4'sd3)
        | (s2_l > 4'sd3); // RULE8
    assign bad_align = (vdst & ~aligned(vd, nd))
        | (us1 & ~aligned(vs1, n1))
        | (us2 & ~aligned(vs2, n2)); // RULE4
    assign bad_eew = us1 & us2 & overlap(vs1, n1, vs2, n2)
        & (s1_e != s2_e); // RULE5
    assign bad_ovl = vdst & ((us1 & ~ovl_ok(vd, nd, d_e, vs1, n1, s1_e, s1_l))
        | (us2 & ~ovl_ok(vd, nd, d_e, vs2, n2, s2_e, s2_l))); // RULE6
    // Controlling mask lives in v0; a masked vector destination may not cover it unless it is a mask or reduction result
    assign bad_v0 = ~vm & vdst & (vd == 5'd0) & ~mdst & ~red; // RULE11 RULE12
    assign diff_ovl = vdst & ((us1 & overlap(vd, nd, vs1, n1) & (d_e != s1_e))
        | (us2 & overlap(vd, nd, vs2, n2) & (d_e != s2_e)));
    assign illegal = bad_cfg | bad_size | bad_align | bad_eew
        | bad_ovl | bad_v0; // RULE23

    // Effective agnostic policies
    logic ma_eff;
    logic ta_eff;
    assign ma_eff = state_reg.vtype[VT_VMA] | diff_ovl; // RULE7
    assign ta_eff = state_reg.vtype[VT_VTA] | diff_ovl | mdst; // RULE7 RULE13

    // VLMAX and tail end; fractional groups can run below zero
    logic signed [5:0] vlmax_l;
    logic [IW:0] vlmax;
    logic [IW:0] per_reg;
    logic [IW:0] tail_end;
    always_comb begin
        vlmax_l = 6'(VLEN_LOG) - {sew_l[4], sew_l} + 6'(base_l);
        vlmax = '0;
        if (vlmax_l >= 6'sd0) begin
            vlmax = (IW + 1)'(1) << vlmax_l[4:0];
        end
        per_reg = (IW + 1)'(VLEN) >> sew_l[2:0];
        // Tail reaches the whole register when LMUL is below one
        tail_end = (vlmax > per_reg) ? vlmax : per_reg; // RULE19
    end

    // Mask bit for the queried element, v0 window of 32 elements
    logic mask_on;
    assign mask_on = vm | state_reg.mask[state_reg.idx[4:0]]; // RULE14

    logic [1:0] cls;
    logic wr_res;
    logic wr_ones;
    logic exc_ok;
    logic src_zero;

    vomep_elem_class #(
        .IW(IW)
    ) u_class (
        .idx(state_reg.idx),
        .vstart(state_reg.vstart),
        .vl(state_reg.vl),
        .vlmax(vlmax),
        .tail_end(tail_end),
        .mask_on(mask_on),
        .ma_eff(ma_eff),
        .ta_eff(ta_eff),
        .mask_prod(mask_prod),
        .illegal(illegal),
        .cls(cls),
        .wr_res(wr_res),
        .wr_ones(wr_ones),
        .exc_ok(exc_ok),
        .src_zero(src_zero)
    );

    // Read mux and address decode
    logic hit;
    logic [31:0] rd_val;
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            ADDR_VTYPE: rd_val[7:0] = state_reg.vtype;
            ADDR_VL: rd_val[IW-1:0] = state_reg.vl;
            ADDR_VSTART: rd_val[IW-1:0] = state_reg.vstart;
            ADDR_INST: rd_val = state_reg.inst;
            ADDR_OPCL: rd_val[8:0] = state_reg.opcl;
            ADDR_MASK: rd_val = state_reg.mask;
            ADDR_ELEM: rd_val[IW-1:0] = state_reg.idx;
            ADDR_STAT: begin
                rd_val[0] = illegal;
                rd_val[1] = xfw & ~illegal; // RULE21
                rd_val[2] = state_reg.vstart < state_reg.vl;
                rd_val[4:3] = cls;
                rd_val[5] = wr_res;
                rd_val[6] = wr_ones;
                rd_val[7] = exc_ok;
                rd_val[8] = src_zero;
                rd_val[9] = ma_eff;
                rd_val[10] = ta_eff;
                rd_val[12:11] = src_kind;
                rd_val[13] = diff_ovl;
            end
            ADDR_GEOM: begin
                rd_val[4:0] = nd;
                rd_val[9:5] = n1;
                rd_val[14:10] = n2;
                rd_val[31:15] = vlmax;
            end
            default: hit = 1'b0;
        endcase
    end

    // Next state: bus handshake, register writes, illegal pulse
    always_comb begin
        state_next = state_reg;
        state_next.chk = 1'b0;
        state_next.illegal = state_reg.chk & illegal; // RULE23
        state_next.scalar_we = xfw & ~illegal; // RULE21
        case (state_reg.st)
            ST_IDLE: begin
                state_next.pready = 1'b0;
                state_next.pslverr = 1'b0;
                if (psel && !penable) begin
                    // Answer is prepared in setup so access ends at once
                    state_next.st = ST_ACC;
                    state_next.pready = 1'b1;
                    state_next.pslverr = ~hit;
                    state_next.prdata = pwrite ? 32'h0000_0000 : rd_val;
                end
            end
            ST_ACC: begin
                if (psel && penable) begin
                    state_next.st = ST_IDLE;
                    state_next.pready = 1'b0;
                    state_next.pslverr = 1'b0;
                    state_next.prdata = 32'h0000_0000;
                    if (pwrite) begin
                        case (paddr)
                            ADDR_VTYPE: state_next.vtype = pwdata[7:0];
                            ADDR_VL: state_next.vl = pwdata[IW-1:0];
                            ADDR_VSTART: state_next.vstart = pwdata[IW-1:0];
                            ADDR_INST: begin
                                state_next.inst = pwdata;
                                state_next.chk = 1'b1;
                            end
                            ADDR_OPCL: state_next.opcl = pwdata[8:0];
                            ADDR_MASK: state_next.mask = pwdata;
                            ADDR_ELEM: state_next.idx = pwdata[IW-1:0];
                            default: state_next.chk = 1'b0;
                        endcase
                    end
                end else begin
                    // Master dropped the transfer; return to idle
                    state_next.st = ST_IDLE;
                    state_next.pready = 1'b0;
                    state_next.pslverr = 1'b0;
                    state_next.prdata = 32'h0000_0000;
                end
            end
            default: begin
                state_next.st = ST_IDLE;
                state_next.pready = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.st <= ST_IDLE;
            state_reg.vtype <= VTYPE_RST;
            state_reg.vl <= VL_RST;
            state_reg.vstart <= VSTART_RST;
            state_reg.inst <= INST_RST;
            state_reg.opcl <= OPCL_RST;
            state_reg.mask <= MASK_RST;
            state_reg.idx <= '0;
            state_reg.chk <= 1'b0;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.illegal <= 1'b0;
            state_reg.scalar_we <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign illegal_pulse = state_reg.illegal;
    assign scalar_we = state_reg.scalar_we;
endmodule

/* File: logic/vomep_pkg.sv */
// Package with register map, field positions and encodings of the operand policy block
// What this block does
// [RULE1] Scalar operands come from immediate, x, f or vector element 0.
// [RULE2] By default each operand uses element width SEW and group multiplier LMUL.
// [RULE3] Widening doubles destination width and group; narrowing doubles the wide source.
// [RULE4] Groups are named by their lowest register; misaligned names are reserved.
// [RULE5] Reading one register at two element widths is reserved; mask source is width one. Checked only between vs1 and vs2, not against the v0 mask.
// [RULE6] Destination-source overlap legal only in the three listed width and position cases.
// [RULE7] Overlap with differing widths forces mask- and tail-agnostic handling.
// [RULE8] Any operand group needing more than 8 registers is reserved.
// [RULE9] Widened scalars live in element 0 of a single register.
// [RULE10] Masked-off elements never raise exceptions; handled per mask-agnostic bit.
// [RULE11] The controlling mask always comes from register v0.
// [RULE12] Masked instruction whose vector destination overlaps v0 is reserved, with two exemptions.
// [RULE13] Mask destinations are always tail-agnostic.
// [RULE14] Instruction bit 25 clear means masked by v0, set means unmasked.
// [RULE15] Prestart elements neither trap nor get written.
// [RULE16] Active body elements are computed, written and may trap.
// [RULE17] Inactive body elements do not trap; kept, or all ones when mask-agnostic.
// [RULE18] Tail elements do not trap; kept, all ones, or mask result when tail-agnostic.
// [RULE19] Tail runs from vl up to the larger of VLMAX and VLEN/SEW.
// [RULE20] With vstart at or above vl no destination element is written.
// [RULE21] Scalar x or f results are written even when vstart is at or above vl.
// [RULE22] Source reads with index above VLMAX return zero.
// [RULE23] Reserved encodings are flagged illegal and perform no element updates.
package vomep_pkg;
    localparam logic [7:0] ADDR_VTYPE = 8'h00;
    localparam logic [7:0] ADDR_VL = 8'h04;
    localparam logic [7:0] ADDR_VSTART = 8'h08;
    localparam logic [7:0] ADDR_INST = 8'h0C;
    localparam logic [7:0] ADDR_OPCL = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_ELEM = 8'h18;
    localparam logic [7:0] ADDR_STAT = 8'h1C;
    localparam logic [7:0] ADDR_GEOM = 8'h20;
    // Configuration word fields
    localparam int VT_LMUL_LSB = 0;
    localparam int VT_SEW_LSB = 3;
    localparam int VT_VTA = 6;
    localparam int VT_VMA = 7;
    // Instruction word fields
    localparam int IN_VD_LSB = 7;
    localparam int IN_F3_LSB = 12;
    localparam int IN_VS1_LSB = 15;
    localparam int IN_VS2_LSB = 20;
    localparam int IN_VM = 25;
    // Operation class fields
    localparam int OC_KIND_LSB = 0;
    localparam int OC_MDST = 2;
    localparam int OC_RED = 3;
    localparam int OC_XFW = 4;
    localparam int OC_US1 = 5;
    localparam int OC_US2 = 6;
    localparam int OC_S1MSK = 7;
    localparam int OC_MLD = 8;
    localparam logic [1:0] KIND_NORM = 2'h0;
    localparam logic [1:0] KIND_WIDE = 2'h1;
    localparam logic [1:0] KIND_NARR = 2'h2;
    // Scalar source kinds
    localparam logic [1:0] SRC_VEC0 = 2'h0;
    localparam logic [1:0] SRC_IMM = 2'h1;
    localparam logic [1:0] SRC_XREG = 2'h2;
    localparam logic [1:0] SRC_FREG = 2'h3;
    // Element classes
    localparam logic [1:0] CLS_PRE = 2'h0;
    localparam logic [1:0] CLS_ACT = 2'h1;
    localparam logic [1:0] CLS_INACT = 2'h2;
    localparam logic [1:0] CLS_TAIL = 2'h3;
    // Reset values
    localparam logic [7:0] VTYPE_RST = 8'h00;
    localparam logic [15:0] VL_RST = 16'h0000;
    localparam logic [15:0] VSTART_RST = 16'h0000;
    localparam logic [31:0] INST_RST = 32'h0200_0000;
    localparam logic [8:0] OPCL_RST = 9'h000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam int MAX_GROUP_LOG = 3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACC = 2'b10
    } vomep_st_type;
endpackage

/* File: logic/vomep_elem_class.sv */
// Element classifier: prestart, active, inactive, tail and write policy
`timescale 1ns/1ns
module vomep_elem_class
    import vomep_pkg::*;
#(
    parameter int IW = 16
) (
    input wire logic [IW-1:0] idx,
    input wire logic [IW-1:0] vstart,
    input wire logic [IW-1:0] vl,
    input wire logic [IW:0] vlmax,
    input wire logic [IW:0] tail_end,
    input wire logic mask_on,
    input wire logic ma_eff,
    input wire logic ta_eff,
    input wire logic mask_prod,
    input wire logic illegal,
    output logic [1:0] cls,
    output logic wr_res,
    output logic wr_ones,
    output logic exc_ok,
    output logic src_zero
);
    logic pre;
    logic body;
    logic tail;
    logic frozen;

    // Index partition against vstart, vl and tail end
    assign pre = idx < vstart; // RULE15
    assign body = (idx >= vstart) && (idx < vl);
    assign tail = (idx >= vl) && ({1'b0, idx} < tail_end); // RULE19
    // Nothing is written once vstart reaches vl or the encoding is reserved
    assign frozen = (vstart >= vl) | illegal; // RULE20 RULE23

    always_comb begin
        if (pre) begin
            cls = CLS_PRE;
        end else if (body && mask_on) begin
            cls = CLS_ACT; // RULE16
        end else if (body) begin
            cls = CLS_INACT; // RULE17
        end else begin
            cls = CLS_TAIL; // RULE18
        end
    end

    // Agnostic elements are filled, never left to chance, to stay repeatable
    assign wr_res = ~frozen & ((body & mask_on) | (tail & ta_eff & mask_prod));
    assign wr_ones = ~frozen & ((body & ~mask_on & ma_eff)
        | (tail & ta_eff & ~mask_prod)); // RULE17 RULE18
    // Only active body elements may trap
    assign exc_ok = ~illegal & body & mask_on; // RULE10 RULE16
    assign src_zero = {1'b0, idx} > vlmax; // RULE22
endmodule

/* File: test/vomep_core_model.sv */
// Issuing core model: an APB requester for the operand policy block
`timescale 1ns/1ns
module vomep_core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdata;
    logic rerr;
    // Bus idles low from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* File: test/vomep_chk.sv */
// Port checker for the operand policy block
`timescale 1ns/1ns
module vomep_chk
    import vomep_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic illegal_pulse,
    input wire logic scalar_we
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus phases
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_done;
        psel && penable && pready;
    endsequence
    ready_after_setup_a: assert property (apb_setup |=> pready)
        else $error("pready missing after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (apb_done ##0
        (paddr > ADDR_GEOM || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (apb_done ##0
        (paddr <= ADDR_GEOM && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("mapped access refused");
    illegal_cause_a: assert property (illegal_pulse |->
        $past(psel && penable && pready && pwrite && paddr == ADDR_INST, 2))
        else $error("illegal pulse without instruction write");
    illegal_single_a: assert property (illegal_pulse |=>
        !illegal_pulse)
        else $error("illegal pulse too long");
    scalar_cause_a: assert property ($changed(scalar_we) |->
        $past(psel && penable && pready && pwrite &&
        (paddr == ADDR_VTYPE || paddr == ADDR_INST ||
        paddr == ADDR_OPCL), 2))
        else $error("scalar write changed without cause");
endmodule

/* File: test/tb.sv */
// Self-checking bench for the operand policy block
`timescale 1ns/1ns
module tb;
    import vomep_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic illegal_pulse, scalar_we;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, st;
    int miscompares = 0;
    int checks_done = 0;
    int ill_cnt = 0;
    vomep_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .illegal_pulse(illegal_pulse),
        .scalar_we(scalar_we));
    vomep_core_model core (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Count pulses as the exception logic would see them
    always @(posedge pclk) if (illegal_pulse === 1'b1) ill_cnt++;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        core.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        core.xfer(1'b0, a, 32'h0);
        st = core.rdata;
    endtask
    // Status of one element index, upper status bits ignored
    task automatic ck(input logic [15:0] i, input logic [31:0] e);
        wr(ADDR_ELEM, {16'h0, i});
        rd(ADDR_STAT);
        cmp(st & 32'h3FFF, e);
    endtask
    task automatic t_reset;
        logic [31:0] ex [7] = '{32'h0, 32'h0, 32'h0, 32'h0200_0000,
            32'h0, 32'h0, 32'h0};
        for (int k = 0; k < 7; k++) begin
            rd(8'(4 * k));
            cmp(st, ex[k]);
        end
        rd(8'h24);
        cmp({31'h0, core.rerr}, 32'h1);
    endtask
    task automatic t_class;
        wr(ADDR_VTYPE, 32'h0);
        wr(ADDR_VL, 32'hA);
        wr(ADDR_VSTART, 32'h2);
        wr(ADDR_MASK, 32'h5);
        wr(ADDR_OPCL, 32'h40);
        wr(ADDR_INST, 32'h0040_0100);
        ck(16'h1, 32'h004);
        ck(16'h2, 32'h0AC);
        ck(16'h3, 32'h014);
        ck(16'hC, 32'h01C);
        wr(ADDR_VTYPE, 32'hC0);
        ck(16'h3, 32'h654);
        ck(16'hC, 32'h65C);
        ck(16'h11, 32'h71C);
        wr(ADDR_VSTART, 32'hA);
        ck(16'hC, 32'h618);
        wr(ADDR_VSTART, 32'h2);
        wr(ADDR_INST, 32'h0240_0100);
        ck(16'h3, 32'h6AC);
        wr(ADDR_VTYPE, 32'hC7);
        wr(ADDR_VL, 32'h4);
        wr(ADDR_VSTART, 32'h0);
        ck(16'hA, 32'h75C);
    endtask
    // Reserved and legal neighbours, one row each
    task automatic t_ill;
        logic [7:0] vt [8] = '{8'h01, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00};
        logic [8:0] oc [8] = '{9'h040, 9'h040, 9'h041, 9'h040, 9'h044,
            9'h0E0, 9'h042, 9'h042};
        logic [31:0] in [8] = '{32'h0240_0180, 32'h0240_0100,
            32'h0280_0000, 32'h0040_0000, 32'h0040_0000, 32'h0242_0400,
            32'h0220_0180, 32'h0220_0100};
        logic [7:0] exv = 8'h6D;
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_VTYPE, {24'h0, vt[k]});
            wr(ADDR_OPCL, {23'h0, oc[k]});
            ill_cnt = 0;
            wr(ADDR_INST, in[k]);
            rd(ADDR_STAT);
            cmp({28'h0, ill_cnt == 1, st[0], st[6:5] & {2{exv[k]}}},
                {28'h0, exv[k], exv[k], 2'h0});
        end
        cmp({29'h0, st[13], st[10:9]}, 32'h7);
    endtask
    task automatic t_scal;
        logic [2:0] f3 [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_INST, {17'h0480, f3[k], 12'h100});
            rd(ADDR_STAT);
            cmp({30'h0, st[12:11]}, 32'(k));
        end
        wr(ADDR_VL, 32'h0);
        wr(ADDR_VSTART, 32'h5);
        wr(ADDR_OPCL, 32'h50);
        rd(ADDR_STAT);
        cmp({28'h0, scalar_we, st[1], st[6:5]}, 32'hC);
        wr(ADDR_VTYPE, 32'h1);
        wr(ADDR_OPCL, 32'h41);
        wr(ADDR_INST, 32'h0240_0000);
        rd(ADDR_GEOM);
        cmp({5'h0, st[31:15], st[14:10], st[4:0]},
            {5'h0, 17'h20, 5'h2, 5'h4});
        wr(ADDR_OPCL, 32'h29);
        rd(ADDR_GEOM);
        cmp(st, 32'h0010_0821);
        wr(ADDR_OPCL, 32'h44);
        wr(ADDR_VSTART, 32'h0);
        wr(ADDR_VL, 32'h4);
        ck(16'h8, 32'h43C);
        wr(ADDR_OPCL, 32'h144);
        ck(16'h8, 32'h45C);
    endtask
    task automatic final_report;
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Main sequence: reset, then one scenario after another
    initial begin
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_class();
        t_ill();
        t_scal();
        final_report();
    end
    // Watchdog: all scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        final_report();
    end
endmodule
bind vomep_top vomep_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .illegal_pulse(illegal_pulse), .scalar_we(scalar_we));
